// file: rtl/scs_clock_select.sv
`timescale 1ns/1ps
module scs_clock_select
    import scs_pkg::*;
#(
    parameter int DIVW = 10,
    parameter int AW   = 24
) (
    // Clock and reset
    input  wire logic          I_SYS_CLK,
    input  wire logic          I_RST,
    // APB slave
    input  wire logic          I_PSEL,
    input  wire logic          I_PENABLE,
    input  wire logic          I_PWRITE,
    input  wire logic [11:0]   I_PADDR,
    input  wire logic [31:0]   I_PWDATA,
    output logic      [31:0]   O_PRDATA,
    output logic               O_PREADY,
    output logic               O_PSLVERR,
    // Clock sources (asynchronous pins)
    input  wire logic          I_DIRECT_CLOCK_INPUT,
    input  wire logic          I_CRYSTAL_INPUT,
    input  wire logic          I_INTERNAL_OSC,
    input  wire logic          I_WAKEUP_CLK,
    input  wire logic          I_PLL_CLK,
    // Clock outputs
    output logic               O_SYS_CLK,
    output logic               O_PLL_EN,
    // Flash read port
    input  wire logic          I_FL_REQ,
    input  wire logic [AW-1:0] I_FL_ADDR,
    output logic               O_FL_ACK,
    output logic               O_FL_SEQ
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0]      sel_reg;
    logic            bypass_reg;
    logic            oscsrc_reg;
    logic [DIVW-1:0] div_reg;
    logic [3:0]      ws_reg;
    logic            wsext_reg;
    logic [4:0]      src_sync;
    logic            s_direct, s_xtal, s_int, s_wu, s_pll;
    logic            osc, osc_dly_reg, osc_rise;
    logic [DIVW-1:0] pcnt_reg;
    logic            presc_clk;
    logic            sys_next;
    logic [4:0]      wait_total;
    logic            busy_reg, pf_valid_reg, seq;
    logic [4:0]      wcnt_reg, pfcnt_reg;
    logic [AW-1:0]   next_addr_reg;
    logic            take;
    logic            apb_setup, apb_wr;
    logic [31:0]     rd_mux;
    logic            rd_err;

    ////////////////////////////////////////////////////////////////////////
    scs_sync #(.W(5)) u_sync (
        .i_clk (I_SYS_CLK),
        .i_rst (I_RST),
        .i_d   ({I_PLL_CLK, I_WAKEUP_CLK, I_INTERNAL_OSC,
                 I_CRYSTAL_INPUT, I_DIRECT_CLOCK_INPUT}),
        .o_q   (src_sync)
    );
    assign {s_pll, s_wu, s_int, s_xtal, s_direct} = src_sync;

    ////////////////////////////////////////////////////////////////////////
    // APB: answer registered in setup, zero wait states
    assign apb_setup = I_PSEL && !I_PENABLE;
    assign apb_wr    = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        unique case (I_PADDR)
            SCS_SYSCFG_OFS: rd_mux[SCS_SEL_LSB +: 2] = sel_reg;
            SCS_PLLCFG_OFS: begin
                rd_mux[SCS_BYPASS_BIT]        = bypass_reg;
                rd_mux[SCS_OSCSRC_BIT]        = oscsrc_reg;
                rd_mux[SCS_DIV_LSB +: DIVW]   = div_reg;
            end
            SCS_IMBCFG_OFS: begin
                rd_mux[SCS_WS_LSB +: 4]       = ws_reg;
                rd_mux[SCS_WSEXT_BIT]         = wsext_reg;
            end
            SCS_STATUS_OFS: begin
                rd_mux[5:0] = {sel_reg, pf_valid_reg, O_PLL_EN,
                               busy_reg, O_SYS_CLK};
            end
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= 32'h0000_0000;
        end else begin
            O_PREADY  <= apb_setup;
            O_PSLVERR <= apb_setup && rd_err;
            O_PRDATA  <= (apb_setup && !I_PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // Writes to unmapped or status offsets are dropped
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            sel_reg    <= SCS_SEL_RST;
            bypass_reg <= SCS_BYPASS_RST;
            oscsrc_reg <= 1'b0;
            div_reg    <= SCS_DIV_RST;
            ws_reg     <= SCS_WS_RST;
            wsext_reg  <= 1'b0;
        end else if (apb_wr) begin
            if (I_PADDR == SCS_SYSCFG_OFS)
                sel_reg <= I_PWDATA[SCS_SEL_LSB +: 2];
            if (I_PADDR == SCS_PLLCFG_OFS) begin
                bypass_reg <= I_PWDATA[SCS_BYPASS_BIT];
                oscsrc_reg <= I_PWDATA[SCS_OSCSRC_BIT];
                div_reg    <= I_PWDATA[SCS_DIV_LSB +: DIVW];
            end
            if (I_PADDR == SCS_IMBCFG_OFS) begin
                ws_reg    <= I_PWDATA[SCS_WS_LSB +: 4];
                wsext_reg <= I_PWDATA[SCS_WSEXT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler counts oscillator rising edges
    assign osc      = oscsrc_reg ? s_int : s_xtal;
    assign osc_rise = osc && !osc_dly_reg;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            osc_dly_reg <= 1'b0;
            pcnt_reg    <= '0;
        end else begin
            osc_dly_reg <= osc;
            if (osc_rise) // RULE_04 RULE_06
                pcnt_reg <= (pcnt_reg >= div_reg) ? '0 : pcnt_reg + 1'b1;
        end
    end

    // Factor one passes osc through so its duty cycle survives
    assign presc_clk = (div_reg == '0) ? osc : // RULE_02 RULE_05
        ({1'b0, pcnt_reg} < ({1'b0, div_reg} + 1'b1) >> 1);       // RULE_04

    always_comb begin
        unique case (scs_sel_t'(sel_reg))
            SCS_SEL_DIRECT: sys_next = s_direct;              // RULE_01
            SCS_SEL_OSC:    sys_next = bypass_reg ? presc_clk // RULE_03
                                                  : s_pll;    // RULE_11
            SCS_SEL_WAKEUP: sys_next = s_wu;                  // RULE_12
            SCS_SEL_RSVD:   sys_next = s_wu;
        endcase
    end

    // Single registered system clock, whichever source feeds it
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_SYS_CLK <= 1'b0;                                   // RULE_07
            O_PLL_EN  <= 1'b0;
        end else begin
            O_SYS_CLK <= sys_next;                               // RULE_07
            O_PLL_EN  <= (sel_reg == SCS_SEL_OSC) && !bypass_reg; // RULE_11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash access: full wait for random, prefetch remainder for sequential
    assign wait_total = {1'b0, ws_reg} + {4'h0, wsext_reg};
    assign seq  = pf_valid_reg && (I_FL_ADDR == next_addr_reg);
    assign take = !busy_reg && I_FL_REQ && !O_FL_ACK;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_FL_ACK      <= 1'b0;
            O_FL_SEQ      <= 1'b0;
            busy_reg      <= 1'b0;
            pf_valid_reg  <= 1'b0;
            wcnt_reg      <= 5'h00;
            pfcnt_reg     <= 5'h00;
            next_addr_reg <= '0;
        end else begin
            O_FL_ACK <= 1'b0;
            if (pfcnt_reg != 5'h00)
                pfcnt_reg <= pfcnt_reg - 5'h01;
            if (take) begin
                busy_reg <= 1'b1;
                O_FL_SEQ <= seq;
                if (seq) begin
                    wcnt_reg <= pfcnt_reg;                       // RULE_09
                end else begin
                    wcnt_reg     <= wait_total;                  // RULE_08
                    pf_valid_reg <= 1'b0;
                end
            end else if (busy_reg) begin
                if (wcnt_reg == 5'h00) begin
                    O_FL_ACK      <= 1'b1;
                    busy_reg      <= 1'b0;
                    next_addr_reg <= I_FL_ADDR + 1'b1;
                    pf_valid_reg  <= 1'b1;                       // RULE_09
                    pfcnt_reg     <= wait_total;
                end else begin
                    wcnt_reg <= wcnt_reg - 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertion helpers
    logic [5:0] lat_cnt;
    logic [4:0] take_wait;
    logic       take_seq;
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            lat_cnt   <= 6'h00;
            take_wait <= 5'h00;
            take_seq  <= 1'b0;
        end else if (take) begin
            lat_cnt   <= 6'h00;
            take_wait <= wait_total;
            take_seq  <= seq;
        end else if (busy_reg) begin
            lat_cnt <= lat_cnt + 6'h01;
        end
    end

    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    property p_direct;
        sel_reg == SCS_SEL_DIRECT |=> O_SYS_CLK == $past(s_direct);
    endproperty
    a_direct: assert property (p_direct) else $error("bad direct"); // RULE_01

    property p_div1;
        sel_reg == SCS_SEL_OSC && bypass_reg && div_reg == '0
            |=> O_SYS_CLK == $past(osc);
    endproperty
    a_div1: assert property (p_div1) else $error("bad factor one"); // RULE_05

    property p_presc;
        sel_reg == SCS_SEL_OSC && bypass_reg |=> O_SYS_CLK == $past(presc_clk);
    endproperty
    a_presc: assert property (p_presc) else $error("no prescaler"); // RULE_03

    property p_wrap;
        osc_rise && pcnt_reg == div_reg && $stable(div_reg) |=> pcnt_reg == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("bad wrap"); // RULE_04

    property p_range;
        pcnt_reg <= div_reg ##1 $stable(div_reg) |-> pcnt_reg <= div_reg;
    endproperty
    a_range: assert property (p_range) else $error("count too big"); // RULE_06

    property p_pll;
        sel_reg == SCS_SEL_OSC && !bypass_reg
            |=> O_PLL_EN && O_SYS_CLK == $past(s_pll);
    endproperty
    a_pll: assert property (p_pll) else $error("pll not selected"); // RULE_11

    property p_wake;
        sel_reg == SCS_SEL_WAKEUP |=> !O_PLL_EN && O_SYS_CLK == $past(s_wu);
    endproperty
    a_wake: assert property (p_wake) else $error("no wakeup"); // RULE_12

    property p_nonseq;
        O_FL_ACK && !take_seq |-> lat_cnt == {1'b0, take_wait} + 6'h01;
    endproperty
    a_nonseq: assert property (p_nonseq) else $error("bad wait"); // RULE_08

    property p_seq;
        take && seq && pfcnt_reg == 5'h00 |=> busy_reg ##1 O_FL_ACK;
    endproperty
    a_seq: assert property (p_seq) else $error("prefetch hit slow"); // RULE_09

    property p_apb;
        apb_setup |=> O_PREADY ##1 !O_PREADY;
    endproperty
    a_apb: assert property (p_apb) else $error("apb ready timing");

    c_direct: cover property (sel_reg == SCS_SEL_DIRECT ##1 O_SYS_CLK);
    c_max:    cover property (div_reg == 10'h3ff && osc_rise
                              && pcnt_reg == 10'h3ff);
    c_seq:    cover property (O_FL_ACK && take_seq);
    c_nonseq: cover property (O_FL_ACK && !take_seq);
endmodule

// file: rtl/scs_pkg.sv
// Operation
// RULE_01: Select 11 drives the system clock from the direct clock input.
// RULE_02: Crystal through prescaler, factor one, behaves like direct drive.
// RULE_03: Select 10 with VCO bypass set derives the clock via the prescaler.
// RULE_04: Prescaled clock is oscillator divided by divider field plus one.
// RULE_05: Factor one passes the oscillator clock with its own duty cycle.
// RULE_06: Largest divide factor is 1024, giving the slowest system clock.
// RULE_07: One system clock times everything, whatever mechanism produces it.
// RULE_08: Wait states delay non-sequential flash reads in full.
// RULE_09: Prefetch fetches ahead so sequential reads finish sooner.
// RULE_10: Software sets wait states and extension to suit the system clock.
// RULE_11: Select 10 with bypass clear enables the PLL and uses its output.
// RULE_12: Select 00 runs the system clock from the wakeup clock source.
package scs_pkg;
    // APB register byte offsets
    localparam logic [11:0] SCS_SYSCFG_OFS = 12'h000;
    localparam logic [11:0] SCS_PLLCFG_OFS = 12'h004;
    localparam logic [11:0] SCS_IMBCFG_OFS = 12'h008;
    localparam logic [11:0] SCS_STATUS_OFS = 12'h00c;
    // Field positions
    localparam int SCS_SEL_LSB      = 0;
    localparam int SCS_BYPASS_BIT   = 0;
    localparam int SCS_OSCSRC_BIT   = 1;
    localparam int SCS_DIV_LSB      = 16;
    localparam int SCS_WS_LSB       = 0;
    localparam int SCS_WSEXT_BIT    = 4;
    // Reset values
    localparam logic [1:0] SCS_SEL_RST    = 2'h0;
    localparam logic       SCS_BYPASS_RST = 1'h1;
    localparam logic [9:0] SCS_DIV_RST    = 10'h000;
    localparam logic [3:0] SCS_WS_RST     = 4'h4;
    // Clock source select codes
    typedef enum logic [1:0] {
        SCS_SEL_WAKEUP = 2'b00,
        SCS_SEL_RSVD   = 2'b01,
        SCS_SEL_OSC    = 2'b10,
        SCS_SEL_DIRECT = 2'b11
    } scs_sel_t;
endpackage

// file: rtl/scs_sync.sv
`timescale 1ns/1ps
module scs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_reg;

    // First stage read by the second stage only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= '0;
            o_q      <= '0;
        end else begin
            meta_reg <= i_d;
            o_q      <= meta_reg;
        end
    end
endmodule

// file: test/scs_src_model.sv
`timescale 1ns/1ps
module scs_src_model #(
    parameter int HI [5] = '{3, 2, 3, 5, 2},
    parameter int LO [5] = '{7, 4, 5, 9, 3}
) (
    // Source clock levels: direct, crystal, internal, wakeup, pll
    output logic [4:0] o_src
);
    // Offset keeps every source edge clear of the sampling edge
    for (genvar g = 0; g < 5; g++) begin : g_src
        initial begin
            o_src[g] = 1'b0;
            #6;
            forever begin
                o_src[g] = 1'b1;
                #(HI[g] * 8);
                o_src[g] = 1'b0;
                #(LO[g] * 8);
            end
        end
    end
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
module tb
    import scs_pkg::*;
;
    localparam int HI [5]    = '{3, 2, 3, 5, 2};
    localparam int LO [5]    = '{7, 4, 5, 9, 3};
    localparam int M_SEL [7] = '{0, 1, 2, 2, 2, 3, 2};
    localparam int M_BYP [7] = '{1, 1, 1, 1, 0, 1, 1};
    localparam int M_OSC [7] = '{0, 0, 0, 1, 0, 0, 1};
    localparam int M_DIV [7] = '{0, 0, 0, 1, 0, 0, 1023};
    localparam int M_SRC [7] = '{3, 3, 1, 2, 4, 0, 2};
    localparam int WS [4]    = '{4, 1, 3, 0};
    localparam int WX [4]    = '{0, 1, 0, 1};
    logic        clk;
    logic        rst;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  src;
    logic        sys_clk;
    logic        pll_en;
    logic        fl_req;
    logic [23:0] fl_addr;
    logic        fl_ack;
    logic        fl_seq;
    logic [31:0] seed;
    int          error_cnt;
    int          check_count;

    scs_clock_select scs_clock_select_i (
        .I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_DIRECT_CLOCK_INPUT(src[0]), .I_CRYSTAL_INPUT(src[1]),
        .I_INTERNAL_OSC(src[2]), .I_WAKEUP_CLK(src[3]), .I_PLL_CLK(src[4]),
        .O_SYS_CLK(sys_clk), .O_PLL_EN(pll_en), .I_FL_REQ(fl_req),
        .I_FL_ADDR(fl_addr), .O_FL_ACK(fl_ack), .O_FL_SEQ(fl_seq)
    );
    scs_src_model #(.HI(HI), .LO(LO)) scs_src_model_i (.o_src(src));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int exp_per(int s, int d);
        return (HI[s] + LO[s]) * (d + 1);
    endfunction
    // Divided clock is high for half the divide factor, rounded down
    function automatic int exp_hi(int s, int d);
        return (d == 0) ? HI[s] : (HI[s] + LO[s]) * ((d + 1) / 2);
    endfunction
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic flash(logic [23:0] a, output int n);
        @(posedge clk);
        fl_req <= 1'b1;
        fl_addr <= a;
        n = 0;
        @(posedge clk);
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (fl_ack !== 1'b1 && n < 200);
        @(posedge clk);
        fl_req <= 1'b0;
    endtask
    // Period and high time of the second full output cycle
    task automatic measure(output int per, output int hi);
        int r;
        logic p;
        per = 0;
        hi = 0;
        r = 0;
        p = 1'b1;
        for (int k = 0; k < 30000 && r < 3; k++) begin
            @(posedge clk);
            #1;
            if (p === 1'b0 && sys_clk === 1'b1) r++;
            if (r == 2) begin
                per++;
                hi += int'(sys_clk === 1'b1);
            end
            p = sys_clk;
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(8 * 100000);
        error_cnt++;
        final_report();
    end
    initial begin
        int s, dv, sel, byp, osc, per, hi, n, w;
        logic [31:0] rd, cfg, a;
        logic er;
        {rst, psel, pen, pwr, fl_req} = 5'h10;
        {paddr, pwdata, fl_addr} = '0;
        seed = 32'h59;
        error_cnt = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        check("outputs in reset", {sys_clk, pll_en, fl_ack}, 0);
        rst <= 1'b0;
        apb(0, SCS_SYSCFG_OFS, 0, rd, er);
        check("select reset", rd, 32'(SCS_SEL_RST));
        apb(0, SCS_PLLCFG_OFS, 0, rd, er);
        check("pll_config reset", rd, 32'(SCS_BYPASS_RST));
        apb(0, SCS_IMBCFG_OFS, 0, rd, er);
        check("wait reset", rd, 32'(SCS_WS_RST));
        apb(0, 12'h010, 0, rd, er);
        check("unmapped error", 32'(er), 32'h0000_0001);
        check("unmapped data", rd, 32'h0000_0000);
        apb(1, SCS_STATUS_OFS, 32'hffffffff, rd, er);
        apb(0, SCS_STATUS_OFS, 0, rd, er);
        check("status ro", rd & 32'h36, 0);
        for (int k = 0; k < 10; k++) begin
            s = k < 7 ? M_SRC[k] : 1;
            sel = k < 7 ? M_SEL[k] : 2;
            byp = k < 7 ? M_BYP[k] : 1;
            osc = k < 7 ? M_OSC[k] : 0;
            dv = k < 7 ? M_DIV[k] : int'(rnd() % 7);
            cfg = 32'(byp) | (32'(osc) << SCS_OSCSRC_BIT) |
                  (32'(dv) << SCS_DIV_LSB);
            apb(1, SCS_PLLCFG_OFS, cfg, rd, er);
            apb(1, SCS_SYSCFG_OFS, 32'(sel), rd, er);
            apb(0, SCS_PLLCFG_OFS, 0, rd, er);
            check("pll_config", rd, cfg);
            apb(0, SCS_STATUS_OFS, 0, rd, er);
            check("status select", (rd >> 4) & 32'h3, 32'(sel));
            check("pll_en", pll_en, 32'(sel == 2 && byp == 0));
            measure(per, hi);
            check("period", per, exp_per(s, dv));
            check("high", hi, exp_hi(s, dv));
        end
        for (int k = 0; k < 4; k++) begin
            w = WS[k] + WX[k];
            cfg = 32'(WS[k]) | (32'(WX[k]) << SCS_WSEXT_BIT);
            apb(1, SCS_IMBCFG_OFS, cfg, rd, er);
            a = rnd();
            flash(a[23:0], n);
            check("nonseq latency", n, w + 1);
            check("nonseq flag", fl_seq, 0);
            repeat (w + 4) @(posedge clk);
            flash(a[23:0] + 24'h1, n);
            check("seq latency", n, 1);
            check("seq flag", fl_seq, 1);
        end
        final_report();
    end
endmodule
